// [core/ivs_scanner.sv]
// readout sequencer: channel scan, reference calibration, result memory
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/10ps
module ivs_scanner #(
  parameter logic [31:0] REF_PERIOD = 32'(ivs_pkg::REF_PERIOD_CYC)
) (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      ce,
  input  wire logic [ivs_pkg::ADDR_W-1:0] addr,
  input  wire logic [ivs_pkg::DATA_W-1:0] wdata,
  input  wire logic                      we,
  input  wire logic                      re,
  output logic      [ivs_pkg::DATA_W-1:0] rdata,
  output logic                           irq,
  output logic      [ivs_pkg::NCH-1:0]   ref_sel,
  output logic      [ivs_pkg::CH_W-1:0]  chan_sel,
  output logic                           adc_start,
  input  wire logic                      adc_done,
  input  wire logic [ivs_pkg::SMP_W-1:0] adc_data,
  output logic                           fault_led
);
  import ivs_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    ivs_state_e                    state;
    logic [CH_W-1:0]               ch;
    logic                          ref_mode;
    logic [NCH-1:0]                upd_mask;
    logic [NCH-1:0]                ref_left;
    logic                          post_pass;
    logic                          post_bad;
    logic                          init_done;
    logic                          card_fault_sw;
    logic                          adc_tmo_flt;
    logic [NCH*GRP_W-1:0]          group;
    logic [SMP_W-1:0]              lim_lo;
    logic [SMP_W-1:0]              lim_hi;
    logic [IRQ_W-1:0]              istat;
    logic [IRQ_W-1:0]              imask;
    logic [NCH-1:0][RES_W-1:0]     res;
    logic [NCH-1:0][SMP_W-1:0]     scale;
    logic [NCH-1:0][SMP_W-1:0]     offs;
    logic [31:0]                   per_cnt;
    logic [TMO_W-1:0]              tmo_cnt;
    logic                          done_s1;
    logic                          done_s2;
    logic                          done_s3;
    logic [SMP_W-1:0]              data_s1;
    logic [SMP_W-1:0]              data_s2;
    logic [SMP_W-1:0]              raw;
    logic [NCH-1:0]                ref_sel;
    logic [CH_W-1:0]               chan_sel;
    logic                          adc_start;
    logic                          div_start;
    logic [DATA_W-1:0]             rdata;
    logic                          led;
  } ivs_regs_s;

  localparam ivs_regs_s RST_VAL = '{
    state:    S_IDLE,
    ref_left: REF_ALL,
    lim_lo:   LIM_LO_RST,
    lim_hi:   LIM_HI_RST,
    scale:    {NCH{SCALE_ONE}},
    led:      1'b1,
    default:  '0
  };

  ivs_regs_s q;
  ivs_regs_s d;

  logic             div_done;
  logic [SMP_W-1:0] div_quo;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [CH_W-1:0] first_fn(input logic [NCH-1:0] m);
    logic [CH_W-1:0] r;
    r = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (m[i]) begin
        r = CH_W'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [NUM_W-1:0] mul_fn(input logic [SMP_W-1:0] a,
                                               input logic [SMP_W-1:0] s);
    logic [NUM_W-1:0] p;
    p = NUM_W'(a) * NUM_W'(s);
    return p >> SCALE_FRAC;
  endfunction

  // channels whose group bit is set in the key
  function automatic logic [NCH-1:0] expand_fn(input logic [NCH-1:0]       key,
                                               input logic [NCH*GRP_W-1:0] grp);
    logic [NCH-1:0] m;
    m = '0;
    for (int i = 0; i < NCH; i++) begin
      m[i] = key[grp[i*GRP_W +: GRP_W]];
    end
    return m;
  endfunction

  function automatic logic [SMP_W-1:0] corr_fn(input logic [SMP_W-1:0] a,
                                               input logic [SMP_W-1:0] s,
                                               input logic [SMP_W-1:0] o);
    logic signed [NUM_W+1:0] v;
    v = $signed({2'b00, mul_fn(a, s)}) + $signed({{(NUM_W-SMP_W+2){o[SMP_W-1]}}, o});
    if (v < 0) begin
      return '0;
    end else if (v > $signed({{(NUM_W-SMP_W+2){1'b0}}, 16'hFFFF})) begin
      return 16'hFFFF;
    end else begin
      return v[SMP_W-1:0];
    end
  endfunction

  ivs_div u_div (
    .clk   (clk),
    .rst   (rst),
    .ce    (ce),
    .start (q.div_start),
    .num   ({REF_NOM, {(NUM_W-SMP_W){1'b0}}} >> (SMP_W - SCALE_FRAC)),
    .den   (q.raw),
    .done  (div_done),
    .quo   (div_quo)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic [IRQ_W-1:0] ev;
    logic [NCH-1:0]   faults;
    logic [NCH-1:0]   km;
    logic             ref_fin;
    logic             done_rise;
    ev        = '0;
    faults    = '0;
    km        = '0;
    ref_fin   = 1'b0;
    done_rise = 1'b0;
    d           = q;
    d.adc_start = 1'b0;
    d.div_start = 1'b0;
    d.rdata     = '0;

    // ****************************************************************
    // converter link
    // ****************************************************************
    // converter handshake comes from another clock, so two flops first
    d.done_s1 = adc_done;
    d.done_s2 = q.done_s1;
    d.done_s3 = q.done_s2;
    d.data_s1 = adc_data;
    d.data_s2 = q.data_s1;
    done_rise = q.done_s2 & ~q.done_s3;

    // periodic reference sweep request; a late sweep simply absorbs the tick
    if (q.per_cnt >= REF_PERIOD - 32'h1) begin
      d.per_cnt = '0;
      d.ref_left = REF_ALL; // [R5]
    end else begin
      d.per_cnt = q.per_cnt + 32'h1;
    end

    // ****************************************************************
    // scan sequencer
    // ****************************************************************
    // one conversion at a time; the lowest pending channel goes first
    case (q.state)
      S_IDLE: begin
        if (|q.upd_mask) begin
          d.ch       = first_fn(q.upd_mask);
          d.ref_mode = 1'b0;
          d.ref_sel  = '0; // [R2]
          d.chan_sel = first_fn(q.upd_mask); // [R3]
          d.state    = S_START;
        end else if (|q.ref_left) begin
          // requested samples drain first, references fill the gaps
          d.ch       = first_fn(q.ref_left); // [R15]
          d.ref_mode = 1'b1;
          d.ref_sel  = NCH'(1) << first_fn(q.ref_left); // [R2] [R5]
          d.chan_sel = first_fn(q.ref_left); // [R3]
          d.state    = S_START;
        end
      end
      S_START: begin
        d.adc_start = 1'b1; // [R3]
        d.tmo_cnt   = '0;
        d.state     = S_WAIT;
      end
      S_WAIT: begin
        if (done_rise) begin
          d.raw   = q.data_s2; // [R1]
          d.state = q.ref_mode ? S_CAL : S_CORR;
        end else if (q.tmo_cnt == ADC_TMO_CYC - TMO_W'(1)) begin
          // a dead converter must not hang the scan: drop the channel
          d.adc_tmo_flt = 1'b1;
          ev[IRQ_ADCTMO] = 1'b1;
          d.ref_sel = '0;
          d.state   = S_IDLE;
          if (q.ref_mode) begin
            ref_fin = 1'b1;
          end else begin
            d.upd_mask[q.ch] = 1'b0;
          end
        end else begin
          d.tmo_cnt = q.tmo_cnt + TMO_W'(1);
        end
      end
      S_CORR: begin
        d.res[q.ch][SMP_W-1:0] = corr_fn(q.raw, q.scale[q.ch], q.offs[q.ch]); // [R4] [R8]
        d.upd_mask[q.ch] = 1'b0; // [R10]
        if (q.upd_mask == (NCH'(1) << q.ch)) begin
          ev[IRQ_KEYDONE] = 1'b1;
        end
        d.state = S_IDLE;
      end
      S_CAL: begin
        d.ref_sel = '0;
        if (q.raw < q.lim_lo || q.raw > q.lim_hi) begin
          // constants are kept from the last good reading
          if (!q.res[q.ch][RES_FLT]) begin
            ev[IRQ_CHFAULT] = 1'b1;
          end
          d.res[q.ch][RES_FLT] = 1'b1; // [R6] [R14]
          d.post_bad = 1'b1;
          ref_fin    = 1'b1;
          d.state    = S_IDLE;
        end else begin
          d.res[q.ch][RES_FLT] = 1'b0; // [R14]
          d.div_start = 1'b1; // [R7]
          d.state     = S_DIV;
        end
      end
      S_DIV: begin
        if (div_done) begin
          d.scale[q.ch] = div_quo; // [R7]
          // the offset soaks up the rounding left by the truncated scale
          d.offs[q.ch]  = SMP_W'(NUM_W'(REF_NOM) - mul_fn(q.raw, div_quo)); // [R7]
          ref_fin = 1'b1;
          d.state = S_IDLE;
        end
      end
      default: begin
        d.state = S_IDLE;
      end
    endcase

    if (ref_fin) begin
      d.ref_left[q.ch] = 1'b0;
      if (d.ref_left == '0) begin
        ev[IRQ_REFDONE] = 1'b1;
        d.post_pass = q.post_pass | ~d.post_bad; // [R12]
        d.post_bad  = 1'b0;
      end
    end

    // ****************************************************************
    // register port
    // ****************************************************************
    if (we) begin
      case (addr)
        A_CTRL: begin
          d.init_done     = wdata[CTRL_INIT];
          d.card_fault_sw = wdata[CTRL_CFAULT];
        end
        A_KEY: begin
          km = expand_fn(wdata[NCH-1:0], q.group); // [R10]
          if (|(km & d.upd_mask)) begin
            ev[IRQ_OVERRUN] = 1'b1;
          end
          d.upd_mask = d.upd_mask | km; // [R10]
        end
        A_GROUP: d.group  = wdata[NCH*GRP_W-1:0]; // [R9]
        A_LIMLO: d.lim_lo = wdata[SMP_W-1:0];
        A_LIMHI: d.lim_hi = wdata[SMP_W-1:0];
        A_ISTAT: d.istat  = q.istat & ~wdata[IRQ_W-1:0];
        A_IMASK: d.imask  = wdata[IRQ_W-1:0];
        default: begin
        end
      endcase
    end
    // a new event beats a simultaneous clear
    d.istat = d.istat | ev;

    for (int i = 0; i < NCH; i++) begin
      faults[i] = q.res[i][RES_FLT];
    end

    if (re) begin
      case (addr)
        A_CTRL:  d.rdata = DATA_W'({q.card_fault_sw, q.init_done});
        A_STAT:  d.rdata = DATA_W'({q.state, q.post_pass, q.adc_tmo_flt,
                                    |q.ref_left, |q.upd_mask});
        A_GROUP: d.rdata = DATA_W'(q.group);
        A_LIMLO: d.rdata = DATA_W'(q.lim_lo);
        A_LIMHI: d.rdata = DATA_W'(q.lim_hi);
        A_ISTAT: d.rdata = DATA_W'(q.istat);
        A_IMASK: d.rdata = DATA_W'(q.imask);
        A_FAULT: d.rdata = DATA_W'(faults);
        default: begin
          if (addr[ADDR_W-1:CH_W] == A_RES[ADDR_W-1:CH_W]) begin
            d.rdata = DATA_W'(q.res[addr[CH_W-1:0]]); // [R4] [R14]
          end else if (addr[ADDR_W-1:CH_W] == A_SCALE[ADDR_W-1:CH_W]) begin
            d.rdata = DATA_W'(q.scale[addr[CH_W-1:0]]);
          end else if (addr[ADDR_W-1:CH_W] == A_OFFS[ADDR_W-1:CH_W]) begin
            d.rdata = DATA_W'(q.offs[addr[CH_W-1:0]]);
          end
        end
      endcase
    end

    // ****************************************************************
    // fault indicator
    // ****************************************************************
    // lit until self-test and host setup are both done, and on any fault
    d.led = ~(q.post_pass & q.init_done) | (|faults) // [R12] [R13]
            | q.card_fault_sw | q.adc_tmo_flt; // [R13]
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= RST_VAL;
    end else if (ce) begin
      q <= d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign rdata     = q.rdata;
  assign irq       = |(q.istat & q.imask);
  assign ref_sel   = q.ref_sel;
  assign chan_sel  = q.chan_sel;
  assign adc_start = q.adc_start;
  assign fault_led = q.led;

endmodule

// [core/ivs_pkg.sv]
// constants, encodings and timing shared by the isolated voltage input scanner
// Function
// R1: eight isolated channels, each digitized as a 16 bit sample.
// R2: a per-channel selector routes either the channel reference or its field input.
// R3: a second selector picks the one channel fed to the shared converter.
// R4: each corrected sample is written into the host-readable result memory.
// R5: about once a minute, while no inputs are read, every channel reference is converted.
// R6: a reference reading outside the preset limits marks that channel faulted.
// R7: reference readings yield a separate scale and offset constant per channel.
// R8: a raw sample is multiplied by its scale, then its offset is added, before storing.
// R9: the host assigns each channel a rate group during initialization.
// R10: a broadcast key names due rate groups and only their channels are updated.
// R11: after reset the host lights the fault indicator and clears it if its test passes.
// R12: the indicator goes off only after self-test passes and host initialization is done.
// R13: the red indicator is lit while any channel fault or whole-card fault is present.
// R14: each channel fault mark sits in memory beside that channel result.
// R15: reference checks run only between key updates and never displace a requested sample.
package ivs_pkg;

  localparam int NCH      = 8;
  localparam int CH_W     = 3;
  localparam int SMP_W    = 16;
  localparam int GRP_W    = 3;
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;
  localparam int RES_W    = SMP_W + 1;
  localparam int RES_FLT  = SMP_W;
  localparam int NUM_W    = 32;

  // ****************************************************************
  // register map (word addresses)
  // ****************************************************************
  localparam logic [ADDR_W-1:0] A_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] A_STAT   = 8'h01;
  localparam logic [ADDR_W-1:0] A_KEY    = 8'h02;
  localparam logic [ADDR_W-1:0] A_GROUP  = 8'h03;
  localparam logic [ADDR_W-1:0] A_LIMLO  = 8'h04;
  localparam logic [ADDR_W-1:0] A_LIMHI  = 8'h05;
  localparam logic [ADDR_W-1:0] A_ISTAT  = 8'h06;
  localparam logic [ADDR_W-1:0] A_IMASK  = 8'h07;
  localparam logic [ADDR_W-1:0] A_FAULT  = 8'h08;
  localparam logic [ADDR_W-1:0] A_RES    = 8'h10;
  localparam logic [ADDR_W-1:0] A_SCALE  = 8'h18;
  localparam logic [ADDR_W-1:0] A_OFFS   = 8'h20;

  localparam int CTRL_INIT   = 0;
  localparam int CTRL_CFAULT = 1;

  localparam int IRQ_W       = 5;
  localparam int IRQ_KEYDONE = 0;
  localparam int IRQ_CHFAULT = 1;
  localparam int IRQ_REFDONE = 2;
  localparam int IRQ_OVERRUN = 3;
  localparam int IRQ_ADCTMO  = 4;

  // ****************************************************************
  // calibration arithmetic and reset values
  // ****************************************************************
  localparam int                SCALE_FRAC = 14;
  localparam logic [SMP_W-1:0]  SCALE_ONE  = 16'h4000;
  localparam logic [SMP_W-1:0]  REF_NOM    = 16'hC000;
  localparam logic [SMP_W-1:0]  LIM_LO_RST = 16'hBD00;
  localparam logic [SMP_W-1:0]  LIM_HI_RST = 16'hC300;
  localparam logic [NCH-1:0]    REF_ALL    = 8'hFF;
  localparam int                DIV_ITER   = 32;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam longint CLK_HZ         = 40_000_000;
  localparam longint CLK_PERIOD_NS  = 25;
  localparam longint REF_PERIOD_S   = 60;
  localparam longint REF_PERIOD_CYC = REF_PERIOD_S * CLK_HZ;
  localparam longint ADC_TMO_NS     = 100_000;
  localparam int     TMO_W          = 12;
  localparam logic [TMO_W-1:0] ADC_TMO_CYC =
    TMO_W'((ADC_TMO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [5:0] {
    S_IDLE  = 6'b000001,
    S_START = 6'b000010,
    S_WAIT  = 6'b000100,
    S_CORR  = 6'b001000,
    S_CAL   = 6'b010000,
    S_DIV   = 6'b100000
  } ivs_state_e;

endpackage

// [core/ivs_div.sv]
// sequential restoring divider that derives a channel scale constant
`timescale 1ns/10ps
module ivs_div (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     ce,
  input  wire logic                     start,
  input  wire logic [ivs_pkg::NUM_W-1:0] num,
  input  wire logic [ivs_pkg::SMP_W-1:0] den,
  output logic                          done,
  output logic      [ivs_pkg::SMP_W-1:0] quo
);
  import ivs_pkg::*;

  typedef struct packed {
    logic             busy;
    logic             done;
    logic [5:0]       cnt;
    logic [SMP_W:0]   rem;
    logic [NUM_W-1:0] qt;
    logic [SMP_W-1:0] quo;
  } ivs_div_s;

  ivs_div_s q;
  ivs_div_s d;

  always_comb begin
    logic [SMP_W:0]   trial;
    logic [NUM_W-1:0] nq;
    trial = '0;
    nq    = '0;
    d      = q;
    d.done = 1'b0;
    if (start && !q.busy) begin
      d.busy = 1'b1;
      d.cnt  = '0;
      d.rem  = '0;
      d.qt   = num;
    end else if (q.busy) begin
      trial = {q.rem[SMP_W-1:0], q.qt[NUM_W-1]};
      if (trial >= {1'b0, den}) begin
        d.rem = trial - {1'b0, den};
        nq    = {q.qt[NUM_W-2:0], 1'b1};
      end else begin
        d.rem = trial;
        nq    = {q.qt[NUM_W-2:0], 1'b0};
      end
      d.qt  = nq;
      d.cnt = q.cnt + 6'h01;
      if (q.cnt == 6'(DIV_ITER - 1)) begin
        d.busy = 1'b0;
        d.done = 1'b1;
        // a zero divisor gives all ones and saturates like any overflow
        d.quo  = (|nq[NUM_W-1:SMP_W]) ? 16'hFFFF : nq[SMP_W-1:0];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign done = q.done;
  assign quo  = q.quo;

endmodule

// [sim/ivs_scanner_props.sv]
// concurrent checks on the scanner ports
`timescale 1ns/10ps
module ivs_scanner_props (
  input wire logic                       clk,
  input wire logic                       rst,
  input wire logic                       ce,
  input wire logic [ivs_pkg::ADDR_W-1:0] addr,
  input wire logic [ivs_pkg::DATA_W-1:0] wdata,
  input wire logic                       we,
  input wire logic                       re,
  input wire logic [ivs_pkg::DATA_W-1:0] rdata,
  input wire logic                       irq,
  input wire logic [ivs_pkg::NCH-1:0]    ref_sel,
  input wire logic [ivs_pkg::CH_W-1:0]   chan_sel,
  input wire logic                       adc_start,
  input wire logic                       adc_done,
  input wire logic [ivs_pkg::SMP_W-1:0]  adc_data,
  input wire logic                       fault_led
);
  import ivs_pkg::*;
  default clocking cb @(posedge clk); endclocking
  // a frozen block holds its outputs, so checks pause with the enable
  default disable iff (rst || !ce);
  // ****************************************************************
  // register port
  // ****************************************************************
  chk_rdata_idle: assert property (!re |=> rdata == 32'h0)
    else $error("read data not zero outside a read answer");
  chk_unmapped_read: assert property (re && addr == 8'h09 |=> rdata == 32'h0)
    else $error("unmapped read returned nonzero");
  chk_result_width: assert property (
    re && addr >= A_RES && addr < A_SCALE |=> rdata[31:17] == 15'h0)
    else $error("result word upper bits set");
  chk_fault_width: assert property (re && addr == A_FAULT |=> rdata[31:8] == 24'h0)
    else $error("fault word upper bits set");
  chk_mask_off: assert property (
    we && addr == A_IMASK && wdata[IRQ_W-1:0] == 5'h00 |=> !irq)
    else $error("interrupt still high after full mask");
  // ****************************************************************
  // converter link and indicator
  // ****************************************************************
  chk_start_gap: assert property (adc_start |=> !adc_start [*3])
    else $error("convert requests too close");
  chk_sel_hold: assert property (adc_start |=> $stable(chan_sel) && $stable(ref_sel))
    else $error("selectors moved during conversion");
  chk_ref_target: assert property (
    adc_start && ref_sel != 8'h00 |-> ref_sel == (8'h01 << chan_sel))
    else $error("reference routed on a channel not converted");
  chk_led_reset: assert property ($past(rst) |-> fault_led)
    else $error("indicator off right after reset");
  cover property (adc_start && ref_sel != 8'h00);
  cover property (adc_start && ref_sel == 8'h00);
  cover property (irq);
  cover property (we && addr == A_KEY);
  cover property ($rose(adc_done));
endmodule

bind ivs_scanner ivs_scanner_props u_props (.clk(clk), .rst(rst), .ce(ce), .addr(addr),
  .wdata(wdata), .we(we), .re(re), .rdata(rdata), .irq(irq), .ref_sel(ref_sel),
  .chan_sel(chan_sel), .adc_start(adc_start), .adc_done(adc_done), .adc_data(adc_data),
  .fault_led(fault_led));

// [sim/ivs_adc_model.sv]
// converter model answering the scanner's convert requests
`timescale 1ns/10ps
module ivs_adc_model (
  input  wire logic                                  clk,
  input  wire logic                                  rst,
  input  wire logic                                  adc_start,
  input  wire logic [ivs_pkg::NCH-1:0]               ref_sel,
  input  wire logic [ivs_pkg::CH_W-1:0]              chan_sel,
  input  wire logic [ivs_pkg::NCH*ivs_pkg::SMP_W-1:0] ref_v,
  input  wire logic [ivs_pkg::NCH*ivs_pkg::SMP_W-1:0] fld_v,
  output logic                                       adc_done,
  output logic      [ivs_pkg::SMP_W-1:0]             adc_data
);
  import ivs_pkg::*;
  logic [7:0]       cnt;
  logic             slow;
  logic [SMP_W-1:0] smp;
  // prompt and slow answers alternate; data shows inverted while done is low
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 8'h00;
      slow <= 1'b0;
      smp <= 16'h0000;
      adc_done <= 1'b0;
      adc_data <= 16'hFFFF;
    end else if (adc_start) begin
      cnt <= slow ? 8'h28 : 8'h06;
      slow <= !slow;
      smp <= ref_sel[chan_sel] ? ref_v[chan_sel*SMP_W +: SMP_W]
                               : fld_v[chan_sel*SMP_W +: SMP_W];
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
      if (cnt == 8'h04) begin
        adc_done <= 1'b1;
        adc_data <= smp;
      end
      if (cnt == 8'h01) begin
        adc_done <= 1'b0;
        adc_data <= ~smp;
      end
    end
  end
endmodule

// [sim/ivs_scanner_bench.sv]
// self-checking bench for the scanner
`timescale 1ns/10ps
module ivs_scanner_bench;
  import ivs_pkg::*;
  logic clk, rst, ce, we, re, irq, adc_start, adc_done, fault_led;
  logic [ADDR_W-1:0]      addr;
  logic [DATA_W-1:0]      wdata, rdata, v, keep;
  logic [NCH-1:0]         ref_sel;
  logic [CH_W-1:0]        chan_sel;
  logic [SMP_W-1:0]       adc_data;
  logic [NCH*SMP_W-1:0]   ref_v, fld_v;
  logic [47:0]            sc, of, co;
  logic [23:0]            grp;
  int                     errors, checked;

  ivs_scanner #(.REF_PERIOD(32'h7D0)) dut (.clk(clk), .rst(rst), .ce(ce), .addr(addr),
    .wdata(wdata), .we(we), .re(re), .rdata(rdata), .irq(irq), .ref_sel(ref_sel),
    .chan_sel(chan_sel), .adc_start(adc_start), .adc_done(adc_done), .adc_data(adc_data),
    .fault_led(fault_led));
  ivs_adc_model u_adc (.clk(clk), .rst(rst), .adc_start(adc_start), .ref_sel(ref_sel),
    .chan_sel(chan_sel), .ref_v(ref_v), .fld_v(fld_v), .adc_done(adc_done),
    .adc_data(adc_data));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ****************************************************************
  // access tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // polls a status bit, then clears it; a long wait means the sequencer hung
  task automatic wait_bit(input int b);
    logic [31:0] s;
    for (int i = 0; i < 20000; i++) begin
      rd(A_ISTAT, s);
      if (s[b] === 1'b1) begin
        wr(A_ISTAT, 32'h1 << b);
        return;
      end
    end
    errors++;
    $display("mismatch wait for status bit %0d expected 1 seen 0", b);
    end_of_test();
  endtask
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    we = 1'b0;
    re = 1'b0;
    errors = 0;
    checked = 0;
    ref_v = {NCH{REF_NOM}};
    for (int i = 0; i < NCH; i++) begin
      fld_v[i*SMP_W +: SMP_W] = 16'h2000 + 16'(i) * 16'h0110;
      grp[i*GRP_W +: GRP_W] = (i < 2) ? 3'h1 : 3'h2;
    end
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    wait_bit(IRQ_REFDONE);
    rd(A_FAULT, v);
    chk("fault bits", v, 32'h0);
    rd(A_SCALE + 8'h03, v);
    chk("scale ch3", v, 32'(SCALE_ONE));
    chk("led before init", 32'(fault_led), 32'h1);
    wr(A_CTRL, 32'h1);
    settle();
    chk("led after init", 32'(fault_led), 32'h0);
    wr(A_CTRL, 32'h3);
    settle();
    chk("led card fault", 32'(fault_led), 32'h1);
    wr(A_CTRL, 32'h1);
    rd(8'h09, v);
    chk("unmapped read", v, 32'h0);
    $display("test self test done");
    wr(A_GROUP, 32'(grp));
    rd(A_RES + 8'h02, keep);
    wr(A_KEY, 32'h02);
    wait_bit(IRQ_KEYDONE);
    for (int i = 0; i < 2; i++) begin
      rd(A_RES + 8'(i), v);
      chk("group one result", v, 32'(fld_v[i*SMP_W +: SMP_W]));
    end
    rd(A_RES + 8'h02, v);
    chk("other group result", v, keep);
    $display("test key update done");
    ref_v[3*SMP_W +: SMP_W] = 16'hC300;
    ref_v[5*SMP_W +: SMP_W] = 16'h6000;
    wr(A_IMASK, 32'h2);
    wait_bit(IRQ_REFDONE);
    wait_bit(IRQ_REFDONE);
    sc = (48'(REF_NOM) << SCALE_FRAC) / 48'hC300;
    of = 48'(REF_NOM) - ((48'hC300 * sc) >> SCALE_FRAC);
    co = ((48'(fld_v[3*SMP_W +: SMP_W]) * sc) >> SCALE_FRAC) + of;
    rd(A_FAULT, v);
    chk("fault bits", v, 32'h20);
    chk("irq on fault", 32'(irq), 32'h1);
    chk("led channel fault", 32'(fault_led), 32'h1);
    rd(A_SCALE + 8'h03, v);
    chk("scale ch3", v, 32'(sc[15:0]));
    rd(A_OFFS + 8'h03, v);
    chk("offset ch3", v, 32'(of[15:0]));
    rd(A_SCALE + 8'h05, v);
    chk("scale kept ch5", v, 32'(SCALE_ONE));
    wr(A_IMASK, 32'h0);
    settle();
    chk("irq masked", 32'(irq), 32'h0);
    wr(A_ISTAT, 32'h1F);
    wr(A_IMASK, 32'h2);
    settle();
    chk("irq cleared", 32'(irq), 32'h0);
    wr(A_KEY, 32'h04);
    wait_bit(IRQ_KEYDONE);
    rd(A_RES + 8'h03, v);
    chk("corrected ch3", v, {15'h0, 1'b0, co[15:0]});
    rd(A_RES + 8'h05, v);
    chk("faulted ch5", v, {15'h0, 1'b1, fld_v[5*SMP_W +: SMP_W]});
    $display("test calibration done");
    end_of_test();
  end
endmodule
